// >>> rtusd_pkg.sv
// rtusd_pkg: constants, offsets and state codes for the slave request handler
package rtusd_pkg;

	// ==========================================================
	// function and diagnostic codes
	localparam logic [7:0] FUNC_DIAG = 8'h08;
	localparam logic [7:0] FUNC_FORCE = 8'h0F;
	localparam logic [7:0] FUNC_PRESET = 8'h10;
	localparam logic [7:0] FUNC_DEVTYPE = 8'h11;
	localparam logic [15:0] DIAG_ECHO = 16'h0000;
	localparam logic [15:0] DIAG_RESTART = 16'h0001;
	localparam logic [15:0] DIAG_LISTEN = 16'h0004;
	localparam logic [7:0] RESTART_ON = 8'hFF;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] ERR_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILL_DATA = 8'h03;

	// ==========================================================
	// query byte positions and field limits
	localparam logic [8:0] IDX_ADDR = 9'h000;
	localparam logic [8:0] IDX_FUNC = 9'h001;
	localparam logic [8:0] IDX_F1H = 9'h002;
	localparam logic [8:0] IDX_F1L = 9'h003;
	localparam logic [8:0] IDX_F2H = 9'h004;
	localparam logic [8:0] IDX_F2L = 9'h005;
	localparam logic [8:0] IDX_BCNT = 9'h006;
	localparam logic [8:0] IDX_DATA = 9'h007;
	localparam logic [8:0] IDX_MAX = 9'h1FF;
	localparam logic [15:0] MAX_FORCE_PTS = 16'h0800;
	localparam logic [15:0] MAX_PRESET_REGS = 16'h007D;
	localparam logic [7:0] DEVTYPE_BCNT = 8'h05;

	// ==========================================================
	// response kinds and the index of their last byte
	localparam logic [1:0] RESP_NONE = 2'h0;
	localparam logic [1:0] RESP_ECHO = 2'h1;
	localparam logic [1:0] RESP_DEV = 2'h2;
	localparam logic [1:0] RESP_ERR = 2'h3;
	localparam logic [2:0] LEN_ECHO = 3'h5;
	localparam logic [2:0] LEN_DEV = 3'h7;
	localparam logic [2:0] LEN_ERR = 3'h2;

	// ==========================================================
	// register port map and field positions
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_CPU = 3'h1;
	localparam logic [2:0] OFS_MEMKW = 3'h2;
	localparam logic [2:0] OFS_MAXPT = 3'h3;
	localparam logic [2:0] OFS_MAXREG = 3'h4;
	localparam logic [2:0] OFS_STATUS = 3'h5;
	localparam int CPU_RUN_BIT = 0;
	localparam int CPU_WP_BIT = 1;
	localparam int CPU_COPRO_BIT = 2;
	localparam int CPU_EXT_BIT = 3;
	localparam int CPU_REGCAP_LO = 4;
	localparam int ST_LISTEN_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_PEND_BIT = 2;
	localparam logic [7:0] RST_STATION = 8'h01;
	localparam logic [15:0] RST_CPU = 16'h0000;
	localparam logic [15:0] RST_MEMKW = 16'h0000;
	localparam logic [15:0] RST_MAXPT = 16'h0000;
	localparam logic [15:0] RST_MAXREG = 16'h0000;

	// ==========================================================
	// sequencer states
	typedef enum logic [5:0] {
		ST_RX = 6'b000001,
		ST_EVAL = 6'b000010,
		ST_BUILD = 6'b000100,
		ST_FETCH = 6'b001000,
		ST_LOAD = 6'b010000,
		ST_SEND = 6'b100000
	} rtusd_state_e;

endpackage : rtusd_pkg

// >>> rtusd_resp_mem.sv
// rtusd_resp_mem: small reply buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module rtusd_resp_mem #(
	parameter int WIDTH = 8,
	parameter int AW = 3
) (
	input wire logic clk_sys,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_q
);
	logic [WIDTH-1:0] mem [0:(1<<AW)-1];

	// ==========================================================
	// storage, no reset needed: always written before read
	always_ff @(posedge clk_sys) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (clk_en && rd_en) begin
			rd_data_q <= mem[rd_addr];
		end
	end
endmodule : rtusd_resp_mem
`default_nettype wire

// >>> rtusd_slave.sv
// rtusd_slave: loopback, multi-force, multi-preset and device-type handler
// Function
// - diagnostic accepts codes 0, 1, 4 only
// - diagnostic code and data sent high first
// - echo request answered with identical frame
// - restart clears listen-only; broadcast gets no reply
// - restart data 00/FF then 00, else error
// - listen-only request silences all replies except a valid restart
// - listen-only request itself never answered
// - power-up leaves listen-only cleared
// - force starts at start+1; broadcast silent
// - force byte count 1..256, zero means 256
// - force data packed LSB-first, eight per byte
// - forced values applied once at scan start
// - preset byte count equals twice count
// - preset words ascending from start+1, high first
// - device-type never broadcast; count 5, type
// - run byte all ones running, else zero
// - config byte bits: protect, coprocessor, set, capacity
// - second byte holds memory size high byte
// - third byte holds memory size low byte
`timescale 1ns/1ps
`default_nettype none
module rtusd_slave #(
	parameter logic [7:0] DEVICE_TYPE = 8'h5A // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	output logic [7:0] tx_data_q,
	output logic tx_valid_q,
	output logic tx_last_q,
	input wire logic tx_ready,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata_q,
	output logic force_wr_q,
	output logic [15:0] force_point_q,
	output logic [7:0] force_bits_q,
	output logic [7:0] force_mask_q,
	input wire logic scan_start,
	output logic force_apply_q,
	output logic preset_wr_q,
	output logic [15:0] preset_addr_q,
	output logic [15:0] preset_data_q
);
	import rtusd_pkg::*;

	// ==========================================================
	// helper functions
	function automatic logic fits(input logic [15:0] start, input logic [15:0] cnt,
			input logic [15:0] max);
		fits = ({1'b0, start} + {1'b0, cnt}) <= {1'b0, max};
	endfunction : fits

	// lowest point in bit 0; unused high bits masked off
	function automatic logic [7:0] mask_for(input logic [15:0] rem);
		mask_for = (rem >= 16'h0008) ? 8'hFF : ~(8'hFF << rem[2:0]);
	endfunction : mask_for

	// ==========================================================
	// declarations
	rtusd_state_e st_q, st_d;
	logic [7:0] station_q;
	logic [15:0] cpu_q, memkw_q, maxpt_q, maxreg_q;
	logic listen_q, listen_d;
	logic pending_q;
	logic [8:0] rx_idx_q;
	logic [7:0] addr_q, func_q, bcnt_q, hi_q;
	logic [15:0] f1_q, f2_q;
	logic hdr_ok_q;
	logic [1:0] kind_q;
	logic [2:0] len_q, k_q;

	// ==========================================================
	// register port
	wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
	wire wr_cpu = reg_wr && (reg_addr == OFS_CPU);
	wire wr_memkw = reg_wr && (reg_addr == OFS_MEMKW);
	wire wr_maxpt = reg_wr && (reg_addr == OFS_MAXPT);
	wire wr_maxreg = reg_wr && (reg_addr == OFS_MAXREG);
	wire busy = (st_q != ST_RX);
	wire [15:0] status_word = 16'((listen_q << ST_LISTEN_BIT) | (busy << ST_BUSY_BIT)
		| (pending_q << ST_PEND_BIT));
	wire [15:0] rd_mux = (reg_addr == OFS_CTRL) ? {8'h00, station_q} :
		(reg_addr == OFS_CPU) ? cpu_q :
		(reg_addr == OFS_MEMKW) ? memkw_q :
		(reg_addr == OFS_MAXPT) ? maxpt_q :
		(reg_addr == OFS_MAXREG) ? maxreg_q :
		(reg_addr == OFS_STATUS) ? status_word : 16'h0000;

	// software-held settings; read data live one cycle only
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			station_q <= RST_STATION;
			cpu_q <= RST_CPU;
			memkw_q <= RST_MEMKW;
			maxpt_q <= RST_MAXPT;
			maxreg_q <= RST_MAXREG;
			reg_rdata_q <= 16'h0000;
		end else if (clk_en) begin
			if (wr_ctrl) station_q <= reg_wdata[7:0];
			if (wr_cpu) cpu_q <= reg_wdata;
			if (wr_memkw) memkw_q <= reg_wdata;
			if (wr_maxpt) maxpt_q <= reg_wdata;
			if (wr_maxreg) maxreg_q <= reg_wdata;
			reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ==========================================================
	// device-type reply fields
	wire [7:0] run_byte = cpu_q[CPU_RUN_BIT] ? 8'hFF : 8'h00;
	// reserved top three bits stay zero
	wire [7:0] cfg_byte = {3'b000, cpu_q[CPU_REGCAP_LO+1:CPU_REGCAP_LO],
		cpu_q[CPU_EXT_BIT], cpu_q[CPU_COPRO_BIT], cpu_q[CPU_WP_BIT]};

	// ==========================================================
	// receive side decoding
	wire rx_take = rx_valid && (st_q == ST_RX);
	wire in_data = (rx_idx_q >= IDX_DATA);
	wire [8:0] data_idx = rx_idx_q - IDX_DATA;
	wire [8:0] data_exp = (bcnt_q == 8'h00) ? 9'h100 : {1'b0, bcnt_q};
	wire data_live = in_data && hdr_ok_q && (data_idx < data_exp);
	wire is_force = (func_q == FUNC_FORCE);
	wire is_preset = (func_q == FUNC_PRESET);
	wire [16:0] force_bytes = ({1'b0, f2_q} + 17'h00007) >> 3;
	// byte count checked against point count; 256 wraps to zero
	wire hdr15_ok = (f2_q != 16'h0000) && (f2_q <= MAX_FORCE_PTS)
		&& fits(f1_q, f2_q, maxpt_q) && (rx_data == force_bytes[7:0]);
	wire hdr16_ok = (f2_q != 16'h0000) && (f2_q <= MAX_PRESET_REGS)
		&& fits(f1_q, f2_q, maxreg_q) && (rx_data == {f2_q[6:0], 1'b0});
	wire [15:0] pt_off = {4'h0, data_idx, 3'b000};
	wire [15:0] force_pt = f1_q + 16'h0001 + pt_off;
	wire [7:0] force_msk = mask_for(f2_q - pt_off);
	wire [15:0] preset_ad = f1_q + 16'h0001 + {8'h00, data_idx[8:1]};

	// field capture, high byte of each pair first
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_idx_q <= IDX_ADDR;
			addr_q <= 8'h00;
			func_q <= 8'h00;
			f1_q <= 16'h0000;
			f2_q <= 16'h0000;
			bcnt_q <= 8'h00;
			hdr_ok_q <= 1'b0;
			hi_q <= 8'h00;
		end else if (clk_en) begin
			if (st_q == ST_EVAL) begin
				rx_idx_q <= IDX_ADDR;
				hdr_ok_q <= 1'b0;
			end else if (rx_take) begin
				if (rx_idx_q != IDX_MAX) rx_idx_q <= rx_idx_q + 9'h001;
				if (rx_idx_q == IDX_ADDR) addr_q <= rx_data;
				if (rx_idx_q == IDX_FUNC) func_q <= rx_data;
				if (rx_idx_q == IDX_F1H) f1_q[15:8] <= rx_data;
				if (rx_idx_q == IDX_F1L) f1_q[7:0] <= rx_data;
				if (rx_idx_q == IDX_F2H) f2_q[15:8] <= rx_data;
				if (rx_idx_q == IDX_F2L) f2_q[7:0] <= rx_data;
				if (rx_idx_q == IDX_BCNT) begin
					bcnt_q <= rx_data;
					hdr_ok_q <= (is_force && hdr15_ok) || (is_preset && hdr16_ok);
				end
				if (in_data && !data_idx[0]) hi_q <= rx_data;
			end
		end
	end

	// ==========================================================
	// streaming writes toward the controller cpu
	wire match_rx = (addr_q == station_q) || (addr_q == BCAST_ADDR);
	wire do_force = rx_take && data_live && is_force && match_rx;
	wire do_preset = rx_take && data_live && is_preset && match_rx && data_idx[0];

	// one byte of points or one word per strobe
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			force_wr_q <= 1'b0;
			force_point_q <= 16'h0000;
			force_bits_q <= 8'h00;
			force_mask_q <= 8'h00;
			preset_wr_q <= 1'b0;
			preset_addr_q <= 16'h0000;
			preset_data_q <= 16'h0000;
		end else if (clk_en) begin
			force_wr_q <= do_force;
			preset_wr_q <= do_preset;
			if (do_force) begin
				force_point_q <= force_pt;
				force_bits_q <= rx_data & force_msk;
				force_mask_q <= force_msk;
			end
			if (do_preset) begin
				preset_addr_q <= preset_ad;
				preset_data_q <= {hi_q, rx_data};
			end
		end
	end

	// ==========================================================
	// end-of-frame evaluation
	wire for_us = (addr_q == station_q);
	wire is_bcast = (addr_q == BCAST_ADDR);
	wire is_diag = (func_q == FUNC_DIAG) && (rx_idx_q == IDX_BCNT);
	wire code_echo = is_diag && (f1_q == DIAG_ECHO);
	wire code_rst = is_diag && (f1_q == DIAG_RESTART);
	wire code_lsn = is_diag && (f1_q == DIAG_LISTEN);
	wire code_rsv = is_diag && !code_echo && !code_rst && !code_lsn;
	// restart data: first 00 or FF, second zero
	wire rst_ok = ((f2_q[15:8] == 8'h00) || (f2_q[15:8] == RESTART_ON))
		&& (f2_q[7:0] == 8'h00);
	wire mult_fn = is_force || is_preset;
	wire mult_ok = hdr_ok_q && (rx_idx_q == IDX_DATA + data_exp);
	wire dev_q = (func_q == FUNC_DEVTYPE) && (rx_idx_q == IDX_F1H);
	wire set_listen = code_lsn && (for_us || is_bcast);
	wire clr_listen = code_rst && rst_ok && (for_us || is_bcast);
	wire force_done = is_force && mult_ok && (for_us || is_bcast);
	// echo never broadcast by the master, so only addressed echo replies
	wire [1:0] eval_kind = (code_echo || (code_rst && rst_ok)) ? RESP_ECHO :
		(mult_fn && mult_ok) ? RESP_ECHO :
		dev_q ? RESP_DEV :
		((code_rst && !rst_ok) || code_rsv || (mult_fn && !mult_ok)) ? RESP_ERR :
		RESP_NONE;
	// broadcasts never answered; listen flag gates the transmitter only
	wire eval_send = (eval_kind != RESP_NONE) && for_us && !listen_d;
	wire [2:0] eval_len = (eval_kind == RESP_DEV) ? LEN_DEV :
		(eval_kind == RESP_ERR) ? LEN_ERR : LEN_ECHO;

	// restart wins the same frame; power-up reset clears the flag
	assign listen_d = (st_q == ST_EVAL) ? ((listen_q || set_listen) && !clr_listen)
		: listen_q;

	// listen flag and one-shot force application
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			listen_q <= 1'b0;
			pending_q <= 1'b0;
			force_apply_q <= 1'b0;
		end else if (clk_en) begin
			listen_q <= listen_d;
			// a new frame finishing with the scan start keeps its request
			pending_q <= ((st_q == ST_EVAL) && force_done)
				|| (pending_q && !scan_start);
			force_apply_q <= pending_q && scan_start;
		end
	end

	// ==========================================================
	// reply bytes, built into the buffer then streamed out
	function automatic logic [7:0] resp_byte(input logic [1:0] kind, input logic [2:0] k,
			input logic [7:0] ad, input logic [7:0] fn, input logic [15:0] a,
			input logic [15:0] b, input logic [7:0] run, input logic [7:0] cfg,
			input logic [15:0] kw);
		logic [7:0] r;
		r = 8'h00;
		if (kind == RESP_DEV) begin
			case (k)
				3'h0: r = ad;
				3'h1: r = fn;
				3'h2: r = DEVTYPE_BCNT;
				3'h3: r = DEVICE_TYPE;
				3'h4: r = run;
				3'h5: r = cfg;
				3'h6: r = kw[15:8];
				default: r = kw[7:0];
			endcase
		end else if (kind == RESP_ERR) begin
			case (k)
				3'h0: r = ad;
				3'h1: r = fn | ERR_FLAG;
				default: r = EXC_ILL_DATA;
			endcase
		end else begin
			case (k)
				3'h0: r = ad;
				3'h1: r = fn;
				3'h2: r = a[15:8];
				3'h3: r = a[7:0];
				3'h4: r = b[15:8];
				default: r = b[7:0];
			endcase
		end
		resp_byte = r;
	endfunction : resp_byte

	wire [7:0] build_byte = resp_byte(kind_q, k_q, addr_q, func_q, f1_q, f2_q, run_byte,
		cfg_byte, memkw_q);
	wire mem_wr = (st_q == ST_BUILD);
	wire mem_rd = (st_q == ST_FETCH);
	wire [7:0] mem_dout;
	wire tx_fire = tx_valid_q && tx_ready;
	wire k_end = (k_q == len_q);

	rtusd_resp_mem #(
		.WIDTH(8),
		.AW(3)
	) u_resp_mem (
		.clk_sys(clk_sys),
		.clk_en(clk_en),
		.wr_en(mem_wr),
		.wr_addr(k_q),
		.wr_data(build_byte),
		.rd_en(mem_rd),
		.rd_addr(k_q),
		.rd_data_q(mem_dout)
	);

	// ==========================================================
	// sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_RX: if (rx_take && rx_last) st_d = ST_EVAL;
			ST_EVAL: st_d = eval_send ? ST_BUILD : ST_RX;
			ST_BUILD: if (k_end) st_d = ST_FETCH;
			ST_FETCH: st_d = ST_LOAD;
			ST_LOAD: st_d = ST_SEND;
			ST_SEND: if (tx_fire) st_d = tx_last_q ? ST_RX : ST_FETCH;
			default: st_d = ST_RX;
		endcase
	end

	// sequencer registers; reception ignored while a reply is out
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= ST_RX;
			kind_q <= RESP_NONE;
			len_q <= 3'h0;
			k_q <= 3'h0;
		end else if (clk_en) begin
			st_q <= st_d;
			if (st_q == ST_EVAL) begin
				kind_q <= eval_kind;
				len_q <= eval_len;
				k_q <= 3'h0;
			end else if (st_q == ST_BUILD) begin
				k_q <= k_end ? 3'h0 : k_q + 3'h1;
			end else if ((st_q == ST_SEND) && tx_fire && !tx_last_q) begin
				k_q <= k_q + 3'h1;
			end
		end
	end

	// transmit holding register, held until the sink takes it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
		end else if (clk_en) begin
			if (st_q == ST_LOAD) begin
				tx_data_q <= mem_dout;
				tx_valid_q <= 1'b1;
				tx_last_q <= k_end;
			end else if (tx_fire) begin
				tx_valid_q <= 1'b0;
				tx_last_q <= 1'b0;
			end
		end
	end
endmodule : rtusd_slave
`default_nettype wire

// >>> rtusd_slave_properties.sv
// rtusd_slave_properties: port assertions for the slave request handler
`timescale 1ns/1ps
`default_nettype none
module rtusd_slave_checker (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic [7:0] tx_data_q,
	input wire logic tx_valid_q,
	input wire logic tx_last_q,
	input wire logic tx_ready,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata_q,
	input wire logic force_wr_q,
	input wire logic [15:0] force_point_q,
	input wire logic [7:0] force_bits_q,
	input wire logic [7:0] force_mask_q,
	input wire logic scan_start,
	input wire logic force_apply_q,
	input wire logic preset_wr_q,
	input wire logic [15:0] preset_addr_q
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// strobe history, dropped once a reply ends the transfer; force history also dropped on an apply
	logic f_seen_q, p_seen_q;
	logic [15:0] f_last_q, p_last_q;
	always_ff @(posedge clk_sys) begin
		f_seen_q <= reset_n && !tx_valid_q && !force_apply_q && (f_seen_q || force_wr_q);
		p_seen_q <= reset_n && !tx_valid_q && (p_seen_q || preset_wr_q);
		if (force_wr_q) f_last_q <= force_point_q;
		if (preset_wr_q) p_last_q <= preset_addr_q;
	end

	// ==========================================================
	// properties
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
		else $error("read data outside its cycle");
	chk_tx_hold: assert property (tx_valid_q && !tx_ready |=>
		tx_valid_q && $stable(tx_data_q) && $stable(tx_last_q))
		else $error("reply byte changed before acceptance");
	chk_reply_end: assert property (tx_valid_q && tx_ready && tx_last_q |=> !tx_valid_q)
		else $error("reply ran past its last byte");
	chk_reply_gap: assert property (rx_valid && rx_last |=> !tx_valid_q [*6])
		else $error("reply began before evaluation");
	chk_force_mask: assert property (force_wr_q |->
		force_mask_q[0] && (force_bits_q & ~force_mask_q) == 8'h00)
		else $error("force bits outside mask");
	chk_force_step: assert property (force_wr_q && f_seen_q |->
		force_point_q == f_last_q + 16'h0008)
		else $error("force point did not step by eight");
	chk_apply_once: assert property (force_apply_q |-> $past(scan_start) ##1 !force_apply_q)
		else $error("apply not a single pulse after scan");
	chk_preset_step: assert property (preset_wr_q && p_seen_q |->
		preset_addr_q == p_last_q + 16'h0001)
		else $error("preset register not ascending");
endmodule : rtusd_slave_checker

bind rtusd_slave rtusd_slave_checker chk (.clk_sys, .reset_n, .rx_valid, .rx_last,
	.tx_data_q, .tx_valid_q, .tx_last_q, .tx_ready, .reg_rd, .reg_rdata_q, .force_wr_q,
	.force_point_q, .force_bits_q, .force_mask_q, .scan_start, .force_apply_q,
	.preset_wr_q, .preset_addr_q);
`default_nettype wire

// >>> rtusd_master_model.sv
// rtusd_master_model: polling master station sending queries and taking replies
`timescale 1ns/1ps
`default_nettype none
module rtusd_master_model (
	input wire logic clk_sys,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_last,
	input wire logic [7:0] tx_data_q,
	input wire logic tx_valid_q,
	input wire logic tx_last_q,
	output logic tx_ready
);
	logic slow;
	logic [1:0] cnt;
	logic [8:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		slow = 1'b0;
		cnt = 2'h0;
		tx_ready = 1'b0;
	end

	// slow mode grants one cycle in three, so the replier must hold its byte
	always @(posedge clk_sys) begin
		cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		tx_ready <= !slow || cnt == 2'h2;
		if (tx_valid_q && tx_ready) got.push_back({tx_last_q, tx_data_q});
	end

	// one byte per pulse; line inverted between pulses so nothing stale looks valid
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge clk_sys);
			rx_data <= q[i];
			rx_valid <= 1'b1;
			rx_last <= (i == q.size() - 1);
			@(posedge clk_sys);
			rx_data <= ~q[i];
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
		end
	endtask : send
endmodule : rtusd_master_model
`default_nettype wire

// >>> test_rtu_slave_diag_multiwrite_devtype.sv
// test_rtu_slave_diag_multiwrite_devtype: self-checking bench for the slave handler
`timescale 1ns/1ps
`default_nettype none
module test_rtu_slave_diag_multiwrite_devtype;
	import rtusd_pkg::*;
	localparam logic [7:0] DEV_TYPE = 8'h5A; // arbitrary value
	logic clk_sys, reset_n, reg_wr, reg_rd, scan_start;
	logic rx_valid, rx_last, tx_valid_q, tx_last_q, tx_ready;
	logic force_wr_q, force_apply_q, preset_wr_q;
	logic [2:0] reg_addr;
	logic [7:0] rx_data, tx_data_q, force_bits_q, force_mask_q;
	logic [15:0] reg_wdata, reg_rdata_q, force_point_q, preset_addr_q, preset_data_q;
	logic [31:0] fq[$], pq[$];
	logic [7:0] none[$];
	int err_count, n_checks, n_apply;

	rtusd_slave #(.DEVICE_TYPE(DEV_TYPE)) dut (.clk_sys, .reset_n, .clk_en(1'b1), .rx_data,
		.rx_valid, .rx_last, .tx_data_q, .tx_valid_q, .tx_last_q, .tx_ready, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .force_wr_q, .force_point_q,
		.force_bits_q, .force_mask_q, .scan_start, .force_apply_q, .preset_wr_q,
		.preset_addr_q, .preset_data_q);
	rtusd_master_model mdl (.clk_sys, .rx_data, .rx_valid, .rx_last, .tx_data_q,
		.tx_valid_q, .tx_last_q, .tx_ready);

	// ==========================================================
	// clock and strobe logging
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (force_wr_q) fq.push_back({force_point_q, force_mask_q, force_bits_q});
		if (preset_wr_q) pq.push_back({preset_addr_q, preset_data_q});
		if (force_apply_q) n_apply++;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_q, exp);
	endtask : rd
	task automatic scan();
		@(posedge clk_sys);
		scan_start <= 1'b1;
		@(posedge clk_sys);
		scan_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : scan
	// a silent expectation waits out the whole bound before judging
	task automatic xact(input logic [7:0] q[$], input logic [7:0] e[$]);
		int k;
		mdl.got.delete();
		mdl.send(q);
		k = 0;
		while (k < 600 && (e.size() == 0 || mdl.got.size() < e.size())) begin
			@(posedge clk_sys);
			k++;
		end
		if (mdl.got.size() < e.size()) begin
			err_count++;
			finish_test();
		end
		repeat (2) @(posedge clk_sys);
		chk(mdl.got.size(), e.size());
		foreach (e[i]) chk(mdl.got[i], {i == e.size() - 1, e[i]});
	endtask : xact

	// ==========================================================
	// scenarios
	task automatic sc_diag();
		logic [7:0] q[$], e[$];
		logic [15:0] rsv[3] = '{16'h0002, 16'h0100, 16'h0003};
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
		xact(q, q);
		e = {8'h01, FUNC_DIAG | ERR_FLAG, EXC_ILL_DATA};
		foreach (rsv[i]) begin
			q = {8'h01, FUNC_DIAG, rsv[i][15:8], rsv[i][7:0], 8'h00, 8'h00};
			xact(q, e);
		end
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h01, RESTART_ON, 8'h00};
		xact(q, q);
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h01, 8'h12, 8'h00};
		xact(q, e);
		q = {BCAST_ADDR, FUNC_DIAG, 8'h00, 8'h01, 8'h00, 8'h00};
		xact(q, none);
	endtask : sc_diag
	task automatic sc_listen();
		logic [7:0] q[$];
		q = {BCAST_ADDR, FUNC_DIAG, 8'h00, 8'h04, 8'h00, 8'h00};
		xact(q, none);
		rd(OFS_STATUS, 16'h0001);
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h00, 8'h56, 8'h78};
		xact(q, none);
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h01, 8'h12, 8'h00};
		xact(q, none);
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h04, 8'h00, 8'h00};
		xact(q, none);
		q = {8'h01, FUNC_DIAG, 8'h00, 8'h01, 8'h00, 8'h00};
		xact(q, q);
		rd(OFS_STATUS, 16'h0000);
	endtask : sc_listen
	task automatic sc_devtype();
		logic [7:0] q[$], e[$];
		logic [15:0] cpu[2] = '{16'h002F, 16'h0012};
		logic [15:0] kw[2] = '{16'h0123, 16'h0400};
		logic [7:0] cfg[2] = '{8'h17, 8'h09};
		logic [7:0] run[2] = '{8'hFF, 8'h00};
		mdl.slow = 1'b1;
		q = {8'h01, FUNC_DEVTYPE};
		foreach (cpu[i]) begin
			wr(OFS_CPU, cpu[i]);
			wr(OFS_MEMKW, kw[i]);
			e = {q, DEVTYPE_BCNT, DEV_TYPE, run[i], cfg[i], kw[i][15:8], kw[i][7:0]};
			xact(q, e);
		end
		mdl.slow = 1'b0;
		q = {BCAST_ADDR, FUNC_DEVTYPE};
		xact(q, none);
	endtask : sc_devtype
	task automatic sc_force();
		logic [7:0] q[$], e[$];
		wr(OFS_MAXPT, MAX_FORCE_PTS);
		q = {8'h01, FUNC_FORCE, 8'h00, 8'h13, 8'h00, 8'h0A, 8'h02, 8'hA5, 8'h03};
		e = q[0:5];
		fq.delete();
		xact(q, e);
		chk(fq.size(), 2);
		chk(fq[0], 32'h0014FFA5);
		chk(fq[1], 32'h001C0303);
		rd(OFS_STATUS, 16'h0004);
		n_apply = 0;
		scan();
		scan();
		chk(n_apply, 1);
		q = {BCAST_ADDR, FUNC_FORCE, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
		for (int i = 0; i < 256; i++) q.push_back(i[7:0]);
		fq.delete();
		xact(q, none);
		chk(fq.size(), 256);
		chk(fq[255], 32'h07F9FFFF);
		scan();
		chk(n_apply, 2);
		q = {8'h01, FUNC_FORCE, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h01, 8'hFF};
		e = {8'h01, FUNC_FORCE | ERR_FLAG, EXC_ILL_DATA};
		fq.delete();
		xact(q, e);
		chk(fq.size(), 0);
	endtask : sc_force
	task automatic sc_preset();
		logic [7:0] q[$], e[$];
		wr(OFS_MAXREG, 16'h0020);
		q = {8'h01, FUNC_PRESET, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD};
		e = q[0:5];
		pq.delete();
		xact(q, e);
		chk(pq.size(), 2);
		chk(pq[0], 32'h00051234);
		chk(pq[1], 32'h0006ABCD);
		q = {8'h01, FUNC_PRESET, 8'h00, 8'h04, 8'h00, 8'h02, 8'h03, 8'h12, 8'h34, 8'hAB};
		e = {8'h01, FUNC_PRESET | ERR_FLAG, EXC_ILL_DATA};
		xact(q, e);
		chk(pq.size(), 2);
	endtask : sc_preset

	// ==========================================================
	// main sequence
	initial begin
		err_count = 0;
		n_checks = 0;
		n_apply = 0;
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		scan_start = 1'b0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(OFS_STATUS, 16'h0000);
		rd(OFS_CTRL, 16'h0001);
		wr(OFS_STATUS, 16'hFFFF);
		rd(OFS_STATUS, 16'h0000);
		rd(3'h6, 16'h0000);
		sc_diag();
		sc_listen();
		sc_devtype();
		sc_force();
		sc_preset();
		finish_test();
	end
endmodule : test_rtu_slave_diag_multiwrite_devtype
`default_nettype wire
